// >>> design/srwd_pkg.sv
// Constants, codes and carriers for the stop recovery and watchdog block.
// Assumes one system clock; oscillator ticks arrive as same-clock pulses.
package srwd_pkg;
  // Register offsets
  localparam logic [7:0] OFF_SMR  = 8'h0b;
  localparam logic [7:0] OFF_STOP_RECOVERY_EXTRA = 8'h0d;
  localparam logic [7:0] OFF_WDM  = 8'h0f;
  // stop_recovery_control fields
  localparam int SMR_DIV16 = 0;
  localparam int SMR_DIV2  = 1;
  localparam int SMR_SRC   = 2;
  localparam int SMR_DLY   = 5;
  localparam int SMR_POL   = 6;
  localparam int SMR_FLAG  = 7;
  // stop_recovery_extra fields
  localparam int STOP_RECOVERY_EXTRA_SRC  = 0;
  // watchdog_mode fields
  localparam int WDM_TSEL  = 0;
  localparam int WDM_HALT  = 2;
  localparam int WDM_STOP  = 3;
  localparam int WDM_CLK   = 4;
  // Reset values
  localparam logic       SMR_DLY_RST  = 1'b1;
  localparam logic       SMR_POL_RST  = 1'b0;
  localparam logic [1:0] WDM_TSEL_RST = 2'h1;
  localparam logic       WDM_HALT_RST = 1'b1;
  localparam logic       WDM_STOP_RST = 1'b1;
  localparam logic       WDM_CLK_RST  = 1'b0;
  // Timing: write window length in cycles and watchdog terminal counts (period - 1)
  localparam logic [6:0]  LOCK_CYC = 7'h40;
  localparam logic [11:0] TO_256   = 12'h0ff;
  localparam logic [11:0] TO_512   = 12'h1ff;
  localparam logic [11:0] TO_1024  = 12'h3ff;
  localparam logic [11:0] TO_4096  = 12'hfff;

  typedef enum logic [2:0] {
    SRC_RESET = 3'b000, SRC_RSVD = 3'b001, SRC_P31 = 3'b010, SRC_P32 = 3'b011,
    SRC_P33 = 3'b100, SRC_P27 = 3'b101, SRC_NOR4 = 3'b110, SRC_NOR8 = 3'b111
  } srwd_src_t;
  typedef enum logic [1:0] {
    EX_OFF = 2'b00, EX_AND4 = 2'b01, EX_AND8 = 2'b10, EX_RSVD = 2'b11
  } srwd_ext_t;
  typedef enum logic [0:0] {ST_RUN = 1'b0, ST_STOP = 1'b1} srwd_mode_t;
  typedef enum logic [1:0] {
    LK_ARMED = 2'b00, LK_OPEN = 2'b01, LK_SHUT = 2'b10
  } srwd_lock_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } srwd_bus_t;
endpackage

// >>> design/srwd_top.sv
// Stop-mode wake selection, warm/cold flag and retriggerable watchdog.
// Assumes the core gives one-cycle instruction pulses on mclk, and that
// rc_tick/ext_tick are same-clock pulses from the oscillator dividers.
module srwd_top
  import srwd_pkg::*;
#(
  parameter logic PERMANENT_WDT = 1'b0
) (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire srwd_bus_t  bus,
  input  wire logic [7:0] port2_pin,
  input  wire logic [7:0] port2_drive,
  input  wire logic [7:0] port2_is_out,
  input  wire logic [2:0] port3_pin,
  input  wire logic [2:0] port3_analog,
  input  wire logic       wdt_instr,
  input  wire logic       stop_instr,
  input  wire logic       halt_mode,
  input  wire logic       instr_exec,
  input  wire logic       rc_tick,
  input  wire logic       ext_tick,
  output logic [7:0]      rdata,
  output logic            stop_mode,
  output logic            wake,
  output logic            wdt_reset,
  output logic            reset_delay,
  output logic            flag_wr,
  output logic            flag_z,
  output logic            flag_s,
  output logic            flag_v,
  output logic            clk_div16,
  output logic            clk_div2
);

  typedef struct packed {
    logic [7:0]  rdata;
    srwd_mode_t  mode;
    srwd_lock_t  lock;
    logic [6:0]  lock_cnt;
    logic [11:0] wd_cnt;
    logic        wd_en;
    srwd_src_t   src;
    srwd_ext_t   ext;
    logic        dly;
    logic        pol;
    logic        warm;
    logic        div16;
    logic        div2;
    logic [1:0]  tsel;
    logic        hact;
    logic        sact;
    logic        csel;
    logic [7:0]  p2_s1;
    logic [7:0]  p2_s2;
    logic [7:0]  p2_s3;
    logic [7:0]  p2_f;
    logic [2:0]  p3_s1;
    logic [2:0]  p3_s2;
    logic [2:0]  p3_s3;
    logic [2:0]  p3_f;
    logic        por_pend;
    logic        wake;
    logic        wdrst;
    logic        rdly;
    logic        flag_wr;
  } srwd_state_t;

  localparam srwd_state_t RST_STATE = '{
    rdata: 8'h00, mode: ST_RUN, lock: LK_ARMED, lock_cnt: 7'h00,
    wd_cnt: 12'h000, wd_en: PERMANENT_WDT, src: SRC_RESET, ext: EX_OFF,
    dly: SMR_DLY_RST, pol: SMR_POL_RST, warm: 1'b0, div16: 1'b0, div2: 1'b0,
    tsel: WDM_TSEL_RST, hact: WDM_HALT_RST, sact: WDM_STOP_RST,
    csel: WDM_CLK_RST, p2_s1: 8'h00, p2_s2: 8'h00, p2_s3: 8'h00,
    p2_f: 8'h00, p3_s1: 3'h0, p3_s2: 3'h0, p3_s3: 3'h0, p3_f: 3'h0,
    por_pend: 1'b1, wake: 1'b0, wdrst: 1'b0, rdly: 1'b0, flag_wr: 1'b0
  };

  srwd_state_t q;
  srwd_state_t d;

  logic [7:0] p2v;
  logic       src_ok;
  logic       src_lv;
  logic       hit;
  logic       tick;
  logic       run;
  logic       tmo;
  logic       wr_ok;

  // Accept a new level only once the two later stages agree
  function automatic logic [7:0] filt(input logic [7:0] a, input logic [7:0] b,
                                      input logic [7:0] old);
    filt = (a & b) | (old & (a | b));
  endfunction

  function automatic logic [11:0] term(input logic [1:0] sel);
    case (sel)
      2'h0:    term = TO_256;
      2'h1:    term = TO_512;
      2'h2:    term = TO_1024;
      default: term = TO_4096;
    endcase
  endfunction

  assign p2v   = (port2_is_out & port2_drive) | (~port2_is_out & q.p2_f);
  assign tick  = q.csel ? ext_tick : rc_tick;
  assign run   = (q.wd_en | PERMANENT_WDT)
               & ~(halt_mode & ~q.hact & ~PERMANENT_WDT)
               & ~((q.mode == ST_STOP) & ~q.sact & ~PERMANENT_WDT);
  assign tmo   = run & tick & (q.wd_cnt == term(q.tsel));
  assign wr_ok = (q.lock != LK_SHUT);

  always_comb begin
    d          = q;
    src_ok     = 1'b0;
    src_lv     = 1'b0;
    d.rdata    = 8'h00;
    d.wake     = 1'b0;
    d.wdrst    = 1'b0;
    d.rdly     = 1'b0;
    d.flag_wr  = 1'b0;
    d.por_pend = 1'b0;
    if (q.por_pend) begin
      d.rdly = 1'b1;
    end
    d.p2_s1 = port2_pin;
    d.p2_s2 = q.p2_s1;
    d.p2_s3 = q.p2_s2;
    d.p2_f  = filt(q.p2_s2, q.p2_s3, q.p2_f);
    d.p3_s1 = port3_pin;
    d.p3_s2 = q.p3_s1;
    d.p3_s3 = q.p3_s2;
    d.p3_f  = 3'(filt({5'h00, q.p3_s2}, {5'h00, q.p3_s3}, {5'h00, q.p3_f}));

    case (q.src)
      SRC_P31: begin
        src_ok = ~port3_analog[0];
        src_lv = q.p3_f[0];
      end
      SRC_P32: begin
        src_ok = ~port3_analog[1];
        src_lv = q.p3_f[1];
      end
      SRC_P33: begin
        src_ok = ~port3_analog[2];
        src_lv = q.p3_f[2];
      end
      SRC_P27: begin
        src_ok = 1'b1;
        src_lv = p2v[7];
      end
      SRC_NOR4: begin
        src_ok = 1'b1;
        src_lv = ~|p2v[3:0];
      end
      SRC_NOR8: begin
        src_ok = 1'b1;
        src_lv = ~|p2v;
      end
      default: begin
      end
    endcase
    case (q.ext)
      EX_AND4: begin
        src_ok = 1'b1;
        src_lv = &p2v[3:0];
      end
      EX_AND8: begin
        src_ok = 1'b1;
        src_lv = &p2v;
      end
      default: begin
      end
    endcase
    hit = (q.mode == ST_STOP) && src_ok && (src_lv == q.pol);

    // Write window opens at the first instruction after any restart
    case (q.lock)
      LK_ARMED: begin
        if (instr_exec) begin
          d.lock     = LK_OPEN;
          d.lock_cnt = 7'h01;
        end
      end
      LK_OPEN: begin
        if (q.lock_cnt == LOCK_CYC - 7'h01) begin
          d.lock = LK_SHUT;
        end else begin
          d.lock_cnt = q.lock_cnt + 7'h01;
        end
      end
      LK_SHUT: begin
      end
      default: begin
        d.lock = LK_SHUT;
      end
    endcase

    if (bus.wr) begin
      case (bus.addr)
        OFF_SMR: begin
          d.div16 = bus.wdata[SMR_DIV16];
          d.div2  = bus.wdata[SMR_DIV2];
          d.src   = srwd_src_t'(bus.wdata[SMR_SRC +: 3]);
          d.dly   = bus.wdata[SMR_DLY];
          d.pol   = bus.wdata[SMR_POL];
        end
        OFF_STOP_RECOVERY_EXTRA: begin
          d.ext = srwd_ext_t'(bus.wdata[STOP_RECOVERY_EXTRA_SRC +: 2]);
        end
        OFF_WDM: begin
          if (wr_ok) begin
            d.tsel = bus.wdata[WDM_TSEL +: 2];
            d.hact = bus.wdata[WDM_HALT];
            d.sact = bus.wdata[WDM_STOP];
            d.csel = bus.wdata[WDM_CLK];
          end
        end
        default: begin
        end
      endcase
    end
    if (bus.rd && bus.addr == OFF_SMR) begin
      d.rdata = {q.warm, 7'h00};
    end

    if (run && tick) begin
      d.wd_cnt = q.wd_cnt + 12'h001;
    end
    if (wdt_instr) begin
      d.wd_en   = 1'b1;
      d.wd_cnt  = 12'h000;
      d.flag_wr = 1'b1;
    end
    if (stop_instr && q.mode == ST_RUN) begin
      d.mode = ST_STOP;
    end

    if (tmo) begin
      d.wdrst  = 1'b1;
      d.rdly   = 1'b1;
      d.wd_cnt = 12'h000;
      d.wd_en  = PERMANENT_WDT;
      d.lock   = LK_ARMED;
      d.mode   = ST_RUN;
      if (q.mode == ST_STOP) begin
        d.warm = 1'b1;
      end else begin
        d.warm  = 1'b0;
        d.src   = SRC_RESET;
        d.ext   = EX_OFF;
        d.dly   = SMR_DLY_RST;
        d.pol   = SMR_POL_RST;
        d.div16 = 1'b0;
        d.div2  = 1'b0;
        d.tsel  = WDM_TSEL_RST;
        d.hact  = WDM_HALT_RST;
        d.sact  = WDM_STOP_RST;
        d.csel  = WDM_CLK_RST;
      end
    end else if (hit) begin
      d.mode  = ST_RUN;
      d.wake  = 1'b1;
      d.warm  = 1'b1;
      d.rdly  = q.dly;
      d.div16 = 1'b0;
      d.lock  = LK_ARMED;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q <= RST_STATE;
    end else begin
      q <= d;
    end
  end

  assign rdata       = q.rdata;
  assign stop_mode   = q.mode == ST_STOP;
  assign wake        = q.wake;
  assign wdt_reset   = q.wdrst;
  assign reset_delay = q.rdly;
  assign flag_wr     = q.flag_wr;
  assign flag_z      = 1'b0;
  assign flag_s      = 1'b0;
  assign flag_v      = 1'b0;
  assign clk_div16   = q.div16;
  assign clk_div2    = q.div2;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  wake_p27_a: assert property (
    q.mode == ST_STOP && q.src == SRC_P27 && q.ext == EX_OFF && !tmo
    && p2v[7] == q.pol |=> wake && !stop_mode)
    else $error("port-2 bit 7 match did not wake");
  analog_block_a: assert property (
    q.mode == ST_STOP && q.src == SRC_P31 && q.ext == EX_OFF
    && port3_analog[0] |=> !wake)
    else $error("analog port-3 pin woke the device");
  drive_seen_a: assert property (
    q.mode == ST_STOP && q.src == SRC_P27 && q.ext == EX_OFF && !tmo
    && port2_is_out[7] && port2_drive[7] == q.pol |=> wake)
    else $error("driven port-2 level ignored");
  reset_delay_a: assert property (
    wdt_reset |-> reset_delay)
    else $error("watchdog reset without delay");
  wake_delay_a: assert property (
    hit && !tmo |=> reset_delay == $past(q.dly))
    else $error("wake delay does not follow delay bit");
  warm_flag_a: assert property (
    wake |-> q.warm ##1 q.warm || wdt_reset)
    else $error("warm flag not set by wake");
  cold_flag_a: assert property (
    wdt_reset && $past(q.mode) == ST_RUN |-> !q.warm && q.tsel == WDM_TSEL_RST)
    else $error("watchdog reset not cold or not 512");
  and_wake_a: assert property (
    q.mode == ST_STOP && q.ext == EX_AND8 && !tmo && (&p2v) == q.pol |=> wake)
    else $error("extra AND source did not wake");
  refresh_a: assert property (
    wdt_instr && !tmo |=> q.wd_en && q.wd_cnt == 12'h000 && flag_wr)
    else $error("refresh did not restart watchdog");
  lock_a: assert property (
    q.lock == LK_SHUT && bus.wr && bus.addr == OFF_WDM && !tmo
    |=> $stable(q.tsel) && $stable(q.csel) && $stable(q.hact))
    else $error("locked mode register changed");
  stop_keep_a: assert property (
    tmo && q.mode == ST_STOP
    |=> $stable(q.src) && $stable(q.tsel) && reset_delay && q.warm)
    else $error("stop timeout changed registers");
  halt_hold_a: assert property (
    halt_mode && !q.hact && !PERMANENT_WDT && q.mode == ST_RUN && !wdt_instr
    |=> $stable(q.wd_cnt))
    else $error("watchdog counted in halt");

  sync_hold_a: assert property (
    (q.p2_s2 ^ q.p2_s3) != 8'h00
    |=> ((q.p2_f ^ $past(q.p2_f)) & $past(q.p2_s2 ^ q.p2_s3)) == 8'h00)
    else $error("port-2 filter moved while its stages disagree");
  ext_sel_a: assert property (
    q.csel && !ext_tick && !wdt_instr |=> $stable(q.wd_cnt))
    else $error("watchdog counted without external tick");
  rc_sel_a: assert property (
    !q.csel && !rc_tick && !wdt_instr |=> $stable(q.wd_cnt))
    else $error("watchdog counted without oscillator tick");

  wake_c: cover property (q.mode == ST_STOP ##1 wake);
  stop_tmo_c: cover property (tmo && q.mode == ST_STOP);
  lock_c: cover property (q.lock == LK_OPEN ##1 q.lock == LK_SHUT);
  run_tmo_c: cover property (tmo && q.mode == ST_RUN);
  pin_wake_c: cover property (q.mode == ST_STOP && !port2_is_out[7] ##1 wake);
endmodule // srwd_top

// >>> verif/srwd_core_model.sv
// Core-side model: register bus master and instruction pulses.
// Assumes the block samples every input on the rising edge of mclk.
module srwd_core_model
  import srwd_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic [7:0] rdata,
  output srwd_bus_t       bus,
  output logic            wdt_instr,
  output logic            stop_instr,
  output logic            instr_exec
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    bus = '0;
    {wdt_instr, stop_instr, instr_exec} = 3'h0;
  end

  // Software keeps the unused source field and reserved mode bits at zero
  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus.wr <= 1'b0;
  endtask

  task automatic bus_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus.rd <= 1'b0;
    @(negedge mclk);
    d = rdata;
  endtask

  // Mask order: watchdog, stop, any instruction
  task automatic pulse(input logic [2:0] m);
    @(posedge mclk);
    {wdt_instr, stop_instr, instr_exec} <= m;
    @(posedge mclk);
    {wdt_instr, stop_instr, instr_exec} <= 3'h0;
  endtask
endmodule // srwd_core_model

// >>> verif/stop_recovery_and_watchdog_tb.sv
// Self-checking bench for the stop recovery and watchdog block.
// Assumes the core model drives bus and instruction pulses.
module stop_recovery_and_watchdog_tb
  import srwd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic       mclk;
  logic       rst_n;
  srwd_bus_t  bus;
  logic [7:0] port2_drive;
  logic [7:0] port2_is_out;
  logic       halt_mode;
  logic       rc_tick;
  logic       ext_tick;
  logic       use_ext;
  logic [7:0] port2_pin;
  logic [2:0] port3_pin;
  logic [2:0] port3_analog;
  logic       wdt_instr;
  logic       stop_instr;
  logic       instr_exec;
  logic [7:0] rdata;
  logic       stop_mode;
  logic       wake;
  logic       wdt_reset;
  logic       reset_delay;
  logic       flag_wr;
  logic       flag_z;
  logic       flag_s;
  logic       flag_v;
  logic       clk_div16;
  logic       clk_div2;
  int         failures;
  int         n_tests;
  int         cyc;

  srwd_top DUT (
    .mclk(mclk), .rst_n(rst_n), .bus(bus), .port2_pin(port2_pin),
    .port2_drive(port2_drive), .port2_is_out(port2_is_out), .port3_pin(port3_pin),
    .port3_analog(port3_analog), .wdt_instr(wdt_instr), .stop_instr(stop_instr),
    .halt_mode(halt_mode), .instr_exec(instr_exec), .rc_tick(rc_tick),
    .ext_tick(ext_tick), .rdata(rdata), .stop_mode(stop_mode), .wake(wake),
    .wdt_reset(wdt_reset), .reset_delay(reset_delay), .flag_wr(flag_wr),
    .flag_z(flag_z), .flag_s(flag_s), .flag_v(flag_v), .clk_div16(clk_div16),
    .clk_div2(clk_div2)
  );

  srwd_core_model core (
    .mclk(mclk), .rdata(rdata), .bus(bus), .wdt_instr(wdt_instr),
    .stop_instr(stop_instr), .instr_exec(instr_exec)
  );

  always #20 mclk = ~mclk;

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // n back-to-back ticks; the pulse may only follow the last one
  task automatic ticks(input int n, input logic exp);
    logic early;
    early = 1'b0;
    @(posedge mclk);
    rc_tick <= !use_ext;
    ext_tick <= use_ext;
    repeat (n) begin
      @(negedge mclk);
      if (wdt_reset !== 1'b0) early = 1'b1;
    end
    @(posedge mclk);
    rc_tick <= 1'b0;
    ext_tick <= 1'b0;
    @(negedge mclk);
    chk({7'h0, early}, 8'h00, "early timeout");
    chk({6'h0, wdt_reset, reset_delay}, {6'h0, exp, exp}, "timeout");
  endtask

  task automatic test_reads();
    logic [7:0] d;
    logic [7:0] a [4] = '{OFF_SMR, OFF_STOP_RECOVERY_EXTRA, OFF_WDM, 8'h33};
    for (int i = 0; i < 4; i++) begin
      core.bus_rd(a[i], d);
      chk(d, 8'h00, "cold read");
    end
    $display("test_reads done");
  endtask

  task automatic test_wdt();
    core.pulse(3'h1);
    core.bus_wr(OFF_WDM, 8'h0c);
    core.pulse(3'h4);
    @(negedge mclk);
    chk({4'h0, flag_wr, flag_z, flag_s, flag_v}, 8'h08, "flags");
    ticks(200, 1'b0);
    core.pulse(3'h4);
    ticks(256, 1'b1);
    // Window shut: the short timeout is refused, default stays
    core.pulse(3'h1);
    repeat (70) @(posedge mclk);
    core.bus_wr(OFF_WDM, 8'h0c);
    core.pulse(3'h4);
    ticks(256, 1'b0);
    ticks(256, 1'b1);
    // Halt bit clear freezes the count
    core.pulse(3'h1);
    core.bus_wr(OFF_WDM, 8'h08);
    core.pulse(3'h4);
    halt_mode <= 1'b1;
    ticks(300, 1'b0);
    @(posedge mclk);
    halt_mode <= 1'b0;
    ticks(256, 1'b1);
    $display("test_wdt done");
  endtask

  task automatic no_wake(input string m);
    logic seen;
    seen = 1'b0;
    repeat (8) begin
      @(negedge mclk);
      seen = seen | wake;
    end
    chk({7'h0, seen}, 8'h00, m);
  endtask

  task automatic wait_wake();
    for (int i = 0; i < 10; i++) begin
      @(negedge mclk);
      if (wake === 1'b1) break;
    end
  endtask

  task automatic test_stop_tmo();
    logic [7:0] d;
    core.bus_wr(OFF_SMR, 8'h02);
    core.pulse(3'h1);
    core.bus_wr(OFF_WDM, 8'h18);
    core.pulse(3'h4);
    core.pulse(3'h2);
    ticks(256, 1'b0);
    use_ext = 1'b1;
    ticks(256, 1'b1);
    use_ext = 1'b0;
    chk({6'h0, stop_mode, clk_div2}, 8'h01, "stop timeout kept");
    core.bus_rd(OFF_SMR, d);
    chk(d, 8'h80, "warm after stop timeout");
    $display("test_stop_tmo done");
  endtask

  task automatic test_wake(input logic [7:0] stop_recovery_control, input logic [7:0] ext, input logic [7:0] goal,
                           input logic dly);
    logic [7:0] d;
    @(posedge mclk);
    port2_drive <= ~goal;
    core.bus_wr(OFF_SMR, stop_recovery_control);
    core.bus_wr(OFF_STOP_RECOVERY_EXTRA, ext);
    core.pulse(3'h2);
    repeat (3) @(negedge mclk);
    chk({7'h0, stop_mode}, 8'h01, "stopped");
    @(posedge mclk);
    port2_drive <= goal;
    wait_wake();
    chk({5'h0, wake, reset_delay, stop_mode}, {5'h0, 1'b1, dly, 1'b0}, "wake");
    core.bus_rd(OFF_SMR, d);
    chk(d, 8'h80, "warm flag");
    $display("test_wake done");
  endtask

  // Port-2 bit 7 as input: a one-cycle glitch must not wake, a held level must
  task automatic test_pin();
    @(posedge mclk);
    port2_is_out <= 8'h00;
    port2_drive <= 8'h00;
    port2_pin <= 8'hff;
    core.bus_wr(OFF_SMR, 8'h37);
    @(negedge mclk);
    chk({6'h0, clk_div16, clk_div2}, 8'h03, "divider bits");
    core.pulse(3'h2);
    port2_pin <= 8'h7f;
    @(posedge mclk);
    port2_pin <= 8'hff;
    no_wake("port-2 glitch woke");
    @(posedge mclk);
    port2_pin <= 8'h7f;
    wait_wake();
    chk({3'h0, wake, reset_delay, stop_mode, clk_div16, clk_div2}, 8'h19, "pin wake");
    @(posedge mclk);
    port2_is_out <= 8'hff;
    $display("test_pin done");
  endtask

  task automatic test_analog();
    core.bus_wr(OFF_SMR, 8'h48);
    @(posedge mclk);
    port3_analog <= 3'h1;
    port3_pin <= 3'h7;
    core.pulse(3'h2);
    no_wake("analog pin woke");
    @(posedge mclk);
    port3_analog <= 3'h0;
    repeat (2) @(negedge mclk);
    chk({5'h0, wake, reset_delay, stop_mode}, 8'h04, "port-3 wake");
    $display("test_analog done");
  endtask

  task automatic test_reset();
    logic [7:0] d;
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    @(negedge mclk);
    chk({7'h0, reset_delay}, 8'h01, "delay after reset");
    core.bus_rd(OFF_SMR, d);
    chk(d, 8'h00, "cold after reset");
    $display("test_reset done");
  endtask

  initial begin
    mclk = 1'b0;
    rst_n = 1'b0;
    port2_drive = 8'h00;
    port2_is_out = 8'hff;
    halt_mode = 1'b0;
    rc_tick = 1'b0;
    ext_tick = 1'b0;
    use_ext = 1'b0;
    port2_pin = 8'h00;
    port3_pin = 3'h0;
    port3_analog = 3'h0;
    failures = 0;
    n_tests = 0;
    cyc = 0;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    @(negedge mclk);
    chk({7'h0, reset_delay}, 8'h01, "power-on delay");
    test_reads();
    test_wdt();
    test_stop_tmo();
    test_wake(8'h54, 8'h00, 8'h80, 1'b0);
    test_wake(8'h40, 8'h01, 8'h0f, 1'b0);
    test_wake(8'h7c, 8'h00, 8'h00, 1'b1);
    test_pin();
    test_analog();
    test_reset();
    tally_and_finish();
  end
endmodule // stop_recovery_and_watchdog_tb
